// >>> rtl/dcr_pkg.sv
// constants for the downconverter oscillator control register group
package dcr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_SOURCE_ROUTING = 12'h163;
    localparam logic [11:0] ADDR_UPDATE_MODE = 12'h164;
    localparam logic [11:0] ADDR_SELECT_CONTROL = 12'h165;
    localparam logic [11:0] ADDR_FREQ_SELECT = 12'h166;
    localparam logic [11:0] ADDR_FILTER01_FACTOR = 12'h167;
    localparam logic [11:0] ADDR_FILTER23_FACTOR = 12'h168;
    localparam logic [11:0] ADDR_DECIM_CONFIG = 12'h169;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SOURCE_ROUTING = 8'h00;
    localparam logic [7:0] RST_UPDATE_MODE = 8'h00;
    localparam logic [7:0] RST_SELECT_CONTROL = 8'h00;
    localparam logic [7:0] RST_FREQ_SELECT = 8'h00;
    localparam logic [7:0] RST_FILTER01_FACTOR = 8'h00;
    localparam logic [7:0] RST_FILTER23_FACTOR = 8'h00;
    localparam logic [7:0] RST_DECIM_CONFIG = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OSC_LOAD_STROBE_LSB = 4;
    localparam int NEGATIVE_IMAGE_CHOOSE_BIT = 3;
    localparam int OSC_MODE_BIT = 0;
    localparam int LOW_LATENCY_BIT = 4;
    localparam int PIN_SWITCH_AUTOLOAD_DISABLE_BIT = 2;
    localparam int FREQ_SOURCE_BIT = 1;
    localparam int COMMON_LOAD_BIT = 0;
    localparam int UNEQUAL_DECIM_BIT = 7;
    localparam int ACTIVE_FILTER_COUNT_LSB = 4;
    localparam int COMMON_FACTOR_LSB = 0;
    localparam int ODD_FILTER_FACTOR_LSB = 4;
    localparam int EVEN_FILTER_FACTOR_LSB = 0;

    // writable field masks; other bits read as zero
    localparam logic [7:0] MASK_UPDATE_MODE = 8'hF9;
    localparam logic [7:0] MASK_SELECT_CONTROL = 8'h17;
    localparam logic [7:0] MASK_DECIM_CONFIG = 8'hBF;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_EVEN_CONNECT = 2'h0;
    localparam logic [1:0] SRC_ODD_CONNECT = 2'h1;
    localparam logic [1:0] COUNT_DUAL = 2'h0;
    localparam logic [1:0] COUNT_QUAD = 2'h1;
    localparam logic [1:0] COUNT_SINGLE = 2'h2;
    localparam logic [15:0] RATIO_BYPASS = 16'h0001;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int NUM_FILTERS = 4;
    localparam int NUM_LOAD_BITS = 5;

endpackage : dcr_pkg

// >>> rtl/dcr_edge_if.sv
// carrier between the register group and its update edge detector
`timescale 1ns/1ps
interface dcr_edge_if;
    logic [4:0] level;
    logic [4:0] rise;

    modport src
    (
        output level,
        input rise
    );
    modport det
    (
        input level,
        output rise
    );
endinterface : dcr_edge_if

// >>> rtl/dcr_load_edge.sv
// zero-to-one detector for the oscillator update bits
`timescale 1ns/1ps
module dcr_load_edge
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // update levels in, pulses out
    dcr_edge_if.det edge_bus
);

    logic [4:0] prev_level;

    // compare against previous register value only, so a held one never reloads
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            prev_level <= 5'h00;
        else
            prev_level <= edge_bus.level;
    end

    assign edge_bus.rise = edge_bus.level & ~prev_level;

endmodule : dcr_load_edge

// >>> rtl/dcr_regs.sv
// downconverter oscillator control registers and their decoded controls
`timescale 1ns/1ps
module dcr_regs
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port from the serial control logic
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    // device context
    input wire logic i_complex_mode_enable,
    input wire logic [1:0] i_pin_freq_pick,
    // datapath controls
    output logic [3:0] o_filter_connected,
    output logic [3:0] o_osc_load,
    output logic o_negative_image,
    output logic o_phase_coherent,
    output logic o_dsp_bypass,
    output logic [7:0] o_freq_pick,
    output logic [15:0] o_filter_code,
    output logic [63:0] o_filter_ratio,
    output logic [3:0] o_filter_active,
    output logic o_complex_mode
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] source_routing;
    logic [7:0] update_mode;
    logic [7:0] select_control;
    logic [7:0] freq_select;
    logic [7:0] filter01_factor;
    logic [7:0] filter23_factor;
    logic [7:0] decim_config;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            source_routing <= dcr_pkg::RST_SOURCE_ROUTING;
            update_mode <= dcr_pkg::RST_UPDATE_MODE;
            select_control <= dcr_pkg::RST_SELECT_CONTROL;
            freq_select <= dcr_pkg::RST_FREQ_SELECT;
            filter01_factor <= dcr_pkg::RST_FILTER01_FACTOR;
            filter23_factor <= dcr_pkg::RST_FILTER23_FACTOR;
            decim_config <= dcr_pkg::RST_DECIM_CONFIG;
        end
        else if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                dcr_pkg::ADDR_SOURCE_ROUTING: source_routing <= i_reg_wdata;
                dcr_pkg::ADDR_UPDATE_MODE:
                    update_mode <= i_reg_wdata & dcr_pkg::MASK_UPDATE_MODE;
                dcr_pkg::ADDR_SELECT_CONTROL:
                    select_control <= i_reg_wdata & dcr_pkg::MASK_SELECT_CONTROL;
                dcr_pkg::ADDR_FREQ_SELECT: freq_select <= i_reg_wdata;
                dcr_pkg::ADDR_FILTER01_FACTOR: filter01_factor <= i_reg_wdata;
                dcr_pkg::ADDR_FILTER23_FACTOR: filter23_factor <= i_reg_wdata;
                dcr_pkg::ADDR_DECIM_CONFIG:
                    decim_config <= i_reg_wdata & dcr_pkg::MASK_DECIM_CONFIG;
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb
    begin
        unique case (i_reg_addr)
            dcr_pkg::ADDR_SOURCE_ROUTING: next_rdata = source_routing;
            dcr_pkg::ADDR_UPDATE_MODE: next_rdata = update_mode;
            dcr_pkg::ADDR_SELECT_CONTROL: next_rdata = select_control;
            dcr_pkg::ADDR_FREQ_SELECT: next_rdata = freq_select;
            dcr_pkg::ADDR_FILTER01_FACTOR: next_rdata = filter01_factor;
            dcr_pkg::ADDR_FILTER23_FACTOR: next_rdata = filter23_factor;
            dcr_pkg::ADDR_DECIM_CONFIG: next_rdata = decim_config;
            default: next_rdata = dcr_pkg::READ_UNMAPPED;
        endcase
    end

    // read data holds until the next read, so the port may sample late
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd)
            o_reg_rdata <= next_rdata;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_ack <= 1'b0;
        else
            o_reg_ack <= i_reg_wr | i_reg_rd;
    end

    // ----------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------
    logic [3:0] osc_load_strobe;
    logic negative_image_choose;
    logic osc_mode;
    logic low_latency;
    logic pin_switch_autoload_disable;
    logic freq_source;
    logic common_load;
    logic unequal_decim;
    logic [1:0] active_filter_count;
    logic [3:0] common_factor;
    logic [1:0] filter0_source_select;
    logic [1:0] filter1_source_select;
    logic [1:0] filter2_source_select;
    logic [1:0] filter3_source_select;

    assign osc_load_strobe = update_mode[dcr_pkg::OSC_LOAD_STROBE_LSB +: 4];
    assign negative_image_choose = update_mode[dcr_pkg::NEGATIVE_IMAGE_CHOOSE_BIT];
    assign osc_mode = update_mode[dcr_pkg::OSC_MODE_BIT];
    assign low_latency = select_control[dcr_pkg::LOW_LATENCY_BIT];
    assign pin_switch_autoload_disable =
        select_control[dcr_pkg::PIN_SWITCH_AUTOLOAD_DISABLE_BIT];
    assign freq_source = select_control[dcr_pkg::FREQ_SOURCE_BIT];
    assign common_load = select_control[dcr_pkg::COMMON_LOAD_BIT];
    assign unequal_decim = decim_config[dcr_pkg::UNEQUAL_DECIM_BIT];
    assign active_filter_count = decim_config[dcr_pkg::ACTIVE_FILTER_COUNT_LSB +: 2];
    assign common_factor = decim_config[dcr_pkg::COMMON_FACTOR_LSB +: 4];
    assign filter0_source_select = source_routing[1:0];
    assign filter1_source_select = source_routing[3:2];
    assign filter2_source_select = source_routing[5:4];
    assign filter3_source_select = source_routing[7:6];

    // ----------------------------------------------------------------
    // source routing and modes
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_filter_connected <= 4'h0;
        else
        begin
            o_filter_connected[0] <= filter0_source_select == dcr_pkg::SRC_EVEN_CONNECT;
            o_filter_connected[1] <= filter1_source_select == dcr_pkg::SRC_ODD_CONNECT;
            o_filter_connected[2] <= filter2_source_select == dcr_pkg::SRC_EVEN_CONNECT;
            o_filter_connected[3] <= filter3_source_select == dcr_pkg::SRC_ODD_CONNECT;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_negative_image <= 1'b0;
            o_phase_coherent <= 1'b0;
            o_dsp_bypass <= 1'b0;
            o_complex_mode <= 1'b0;
        end
        else
        begin
            // image choice is meaningless in real decimation, so it is masked there
            o_negative_image <= negative_image_choose & i_complex_mode_enable;
            o_phase_coherent <= osc_mode;
            o_dsp_bypass <= low_latency;
            o_complex_mode <= i_complex_mode_enable;
        end
    end

    // ----------------------------------------------------------------
    // frequency select pins
    // ----------------------------------------------------------------
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    logic pin_switch;
    logic auto_load;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end
        else
        begin
            pin_meta <= i_pin_freq_pick;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_switch = pin_sync != pin_prev;
    // a pin switch only matters while the pins own the selection
    assign auto_load = pin_switch & ~freq_source & ~pin_switch_autoload_disable;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_freq_pick <= 8'h00;
        else if (freq_source)
            o_freq_pick <= freq_select;
        else
            o_freq_pick <= {4{pin_sync}};
    end

    // ----------------------------------------------------------------
    // oscillator loads
    // ----------------------------------------------------------------
    dcr_edge_if edge_bus ();

    assign edge_bus.level = {osc_load_strobe, common_load};

    dcr_load_edge u_load_edge
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .edge_bus(edge_bus.det)
    );

    logic [3:0] next_osc_load;

    assign next_osc_load = edge_bus.rise[4:1]
        | {4{edge_bus.rise[0]}}
        | {4{auto_load}};

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_osc_load <= 4'h0;
        else
            o_osc_load <= next_osc_load;
    end

    // ----------------------------------------------------------------
    // decimation
    // ----------------------------------------------------------------
    logic [15:0] next_code;
    logic [3:0] next_active;

    always_comb
    begin
        if (unequal_decim)
            next_code = {filter23_factor[dcr_pkg::ODD_FILTER_FACTOR_LSB +: 4],
                         filter23_factor[dcr_pkg::EVEN_FILTER_FACTOR_LSB +: 4],
                         filter01_factor[dcr_pkg::ODD_FILTER_FACTOR_LSB +: 4],
                         filter01_factor[dcr_pkg::EVEN_FILTER_FACTOR_LSB +: 4]};
        else
            next_code = {4{common_factor}};
    end

    always_comb
    begin
        unique case (active_filter_count)
            dcr_pkg::COUNT_DUAL: next_active = 4'h3;
            dcr_pkg::COUNT_QUAD: next_active = 4'hF;
            dcr_pkg::COUNT_SINGLE: next_active = 4'h1;
            default: next_active = 4'h0;
        endcase
        // low latency bypasses every filter
        if (low_latency)
            next_active = 4'h0;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_filter_code <= 16'h0000;
            o_filter_active <= 4'h0;
        end
        else
        begin
            o_filter_code <= next_code;
            o_filter_active <= next_active;
        end
    end

    // ratio is two to the power of the code; code zero gives one, the bypass
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_filter_ratio <= {4{dcr_pkg::RATIO_BYPASS}};
        else
        begin
            for (int f = 0; f < dcr_pkg::NUM_FILTERS; f++)
                o_filter_ratio[16*f +: 16] <= dcr_pkg::RATIO_BYPASS << next_code[4*f +: 4];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_route_filter_zero: assert property (
        (filter0_source_select == 2'h0) |=> o_filter_connected[0])
        else $error("filter zero not connected on code 00");
    a_single_osc_load: assert property (
        $rose(osc_load_strobe[1]) |=> o_osc_load[1])
        else $error("oscillator one not loaded after its update edge");
    a_image_gated: assert property (
        !i_complex_mode_enable |=> !o_negative_image)
        else $error("negative image applied in real decimation");
    a_phase_mode: assert property (
        ##1 o_phase_coherent == $past(osc_mode))
        else $error("oscillator mode output does not follow its bit");
    a_low_latency_bypass: assert property (
        low_latency |=> o_dsp_bypass && o_filter_active == 4'h0)
        else $error("low latency does not bypass the filters");
    a_autoload_off: assert property (
        (pin_switch_autoload_disable && !edge_bus.rise[0] && edge_bus.rise[4:1] == 4'h0)
        |=> o_osc_load == 4'h0)
        else $error("load issued while automatic loading is disabled");
    a_freq_from_reg: assert property (
        freq_source |=> o_freq_pick == $past(freq_select))
        else $error("register select not followed");
    a_common_load_all: assert property (
        $rose(common_load) |=> o_osc_load == 4'hF)
        else $error("common update did not load all oscillators");
    a_common_factor: assert property (
        !unequal_decim |=> o_filter_code == {4{$past(common_factor)}})
        else $error("common factor not applied to every filter");
    a_ratio_decode: assert property (
        (next_code[3:0] == 4'hF) |=> o_filter_ratio[15:0] == 16'h8000)
        else $error("code 1111 does not decode to 32768");
    a_quad_count: assert property (
        (active_filter_count == 2'h1 && !low_latency) |=> o_filter_active == 4'hF)
        else $error("quad mode did not enable four filters");
    a_held_no_reload: assert property (
        (osc_load_strobe[2] && $past(osc_load_strobe[2]) && !edge_bus.rise[0] && !auto_load)
        |=> !o_osc_load[2])
        else $error("held update bit reloaded its oscillator");

endmodule : dcr_regs

// >>> test/dcr_regs_tb.sv
// self-checking bench for the downconverter oscillator control registers
`timescale 1ns/1ps
module dcr_regs_tb;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    typedef struct {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic cplx;
        logic [7:0] rb;
        int sel;
        logic [63:0] exp;
    } dcr_row_t;
    logic i_clk, i_nrst, i_reg_wr, i_reg_rd, i_complex_mode_enable;
    logic [11:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, o_freq_pick;
    logic [1:0] i_pin_freq_pick;
    logic o_reg_ack, o_negative_image, o_phase_coherent, o_dsp_bypass, o_complex_mode;
    logic [3:0] o_filter_connected, o_osc_load, o_filter_active;
    logic [15:0] o_filter_code;
    logic [63:0] o_filter_ratio;
    int mismatches = 0;
    int num_checks = 0;
    // write, then one decoded output, then read back; reserved bits read 0
    dcr_row_t rows [27] = '{
        '{12'h163, 8'h00, 1'b0, 8'h00, 0, 64'h5}, '{12'h163, 8'h55, 1'b0, 8'h55, 0, 64'hA},
        '{12'h163, 8'hFF, 1'b0, 8'hFF, 0, 64'h0}, '{12'h163, 8'h00, 1'b0, 8'h00, 0, 64'h5},
        '{12'h164, 8'h0F, 1'b0, 8'h09, 1, 64'h0}, '{12'h164, 8'h0F, 1'b1, 8'h09, 1, 64'h1},
        '{12'h164, 8'h09, 1'b1, 8'h09, 8, 64'h1}, '{12'h164, 8'h01, 1'b0, 8'h01, 2, 64'h1},
        '{12'h164, 8'h00, 1'b0, 8'h00, 2, 64'h0}, '{12'h165, 8'h18, 1'b0, 8'h10, 3, 64'h1},
        '{12'h165, 8'h18, 1'b0, 8'h10, 7, 64'h0}, '{12'h165, 8'h00, 1'b0, 8'h00, 3, 64'h0},
        '{12'h169, 8'h70, 1'b0, 8'h30, 7, 64'h0}, '{12'h169, 8'h10, 1'b0, 8'h10, 7, 64'hF},
        '{12'h169, 8'h20, 1'b0, 8'h20, 7, 64'h1}, '{12'h169, 8'h00, 1'b0, 8'h00, 7, 64'h3},
        '{12'h169, 8'h05, 1'b0, 8'h05, 5, 64'h5555},
        '{12'h169, 8'h0F, 1'b0, 8'h0F, 6, 64'h8000_8000_8000_8000},
        '{12'h167, 8'h21, 1'b0, 8'h21, 5, 64'hFFFF}, '{12'h168, 8'h0F, 1'b0, 8'h0F, 5, 64'hFFFF},
        '{12'h169, 8'h85, 1'b0, 8'h85, 5, 64'h0F21},
        '{12'h169, 8'h85, 1'b0, 8'h85, 6, 64'h0001_8000_0004_0002},
        '{12'h165, 8'h02, 1'b0, 8'h02, 4, 64'h0}, '{12'h166, 8'hE4, 1'b0, 8'hE4, 4, 64'hE4},
        '{12'h165, 8'h00, 1'b0, 8'h00, 4, 64'h0}, '{12'h16A, 8'hFF, 1'b0, 8'h00, 8, 64'h0},
        '{12'h162, 8'hFF, 1'b0, 8'h00, 5, 64'h0F21}
    };

    dcr_regs dut
    (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_reg_ack(o_reg_ack), .i_complex_mode_enable(i_complex_mode_enable),
        .i_pin_freq_pick(i_pin_freq_pick), .o_filter_connected(o_filter_connected),
        .o_osc_load(o_osc_load), .o_negative_image(o_negative_image),
        .o_phase_coherent(o_phase_coherent), .o_dsp_bypass(o_dsp_bypass),
        .o_freq_pick(o_freq_pick), .o_filter_code(o_filter_code),
        .o_filter_ratio(o_filter_ratio), .o_filter_active(o_filter_active),
        .o_complex_mode(o_complex_mode)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk(64'(o_reg_ack), 64'h1);
        chk(64'(o_reg_rdata), 64'(exp));
    endtask : rd

    // counts load pulses over a fixed window, so a stray or doubled pulse shows
    task automatic count_load(input logic [3:0] pat, input int expn);
        int n_any;
        int n_hit;
        n_any = 0;
        n_hit = 0;
        repeat (8)
        begin
            @(posedge i_clk);
            #1;
            if (o_osc_load !== 4'h0) n_any++;
            if (o_osc_load === pat) n_hit++;
        end
        chk(64'(n_any), 64'(expn));
        chk(64'(n_hit), 64'(expn));
    endtask : count_load

    function automatic logic [63:0] out_val(input int sel);
        case (sel)
            0: return 64'(o_filter_connected);
            1: return 64'(o_negative_image);
            2: return 64'(o_phase_coherent);
            3: return 64'(o_dsp_bypass);
            4: return 64'(o_freq_pick);
            5: return 64'(o_filter_code);
            6: return o_filter_ratio;
            7: return 64'(o_filter_active);
            default: return 64'(o_complex_mode);
        endcase
    endfunction : out_val

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        i_nrst = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 12'h000;
        i_reg_wdata = 8'h00;
        i_complex_mode_enable = 1'b0;
        i_pin_freq_pick = 2'h0;
        repeat (4) @(posedge i_clk);
        #1;
        chk(o_filter_ratio, 64'h0001_0001_0001_0001);
        chk(64'(o_filter_active), 64'h0);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        chk(64'(o_filter_connected), 64'h5);
        chk(64'(o_filter_active), 64'h3);
        for (int i = 0; i < 7; i++) rd(12'h163 + 12'(i), 8'h00);
        // ordinary cases from the table
        foreach (rows[i])
        begin
            @(posedge i_clk);
            i_complex_mode_enable <= rows[i].cplx;
            wr(rows[i].addr, rows[i].wdata);
            repeat (2) @(posedge i_clk);
            #1;
            chk(out_val(rows[i].sel), rows[i].exp);
            rd(rows[i].addr, rows[i].rb);
        end
        // single oscillator load, exact cycle, then held bit
        wr(12'h164, 8'h10);
        @(posedge i_clk);
        #1;
        chk(64'(o_osc_load), 64'h1);
        @(posedge i_clk);
        #1;
        chk(64'(o_osc_load), 64'h0);
        wr(12'h164, 8'h10);
        count_load(4'h1, 0);
        wr(12'h164, 8'h00);
        count_load(4'h1, 0);
        wr(12'h164, 8'hE0);
        count_load(4'hE, 1);
        wr(12'h164, 8'h00);
        wr(12'h165, 8'h01);
        count_load(4'hF, 1);
        wr(12'h165, 8'h01);
        count_load(4'hF, 0);
        // pin switching: automatic load, blocked, register-owned
        wr(12'h165, 8'h00);
        @(posedge i_clk);
        i_pin_freq_pick <= 2'h2;
        count_load(4'hF, 1);
        chk(64'(o_freq_pick), 64'hAA);
        wr(12'h165, 8'h04);
        @(posedge i_clk);
        i_pin_freq_pick <= 2'h1;
        count_load(4'hF, 0);
        chk(64'(o_freq_pick), 64'h55);
        wr(12'h165, 8'h02);
        @(posedge i_clk);
        i_pin_freq_pick <= 2'h3;
        count_load(4'hF, 0);
        chk(64'(o_freq_pick), 64'hE4);
        // second reset in mid-run clears the routing outputs and the registers
        @(posedge i_clk);
        i_nrst <= 1'b0;
        #1;
        chk(64'(o_filter_connected), 64'h0);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(12'h169, 8'h00);
        rd(12'h166, 8'h00);
        print_verdict();
    end
endmodule : dcr_regs_tb
